// ---- tb/twc_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module twc_bus_model (
	// clock
	input wire logic clk_sys_i,
	// resolved lines
	input wire logic scl_i,
	input wire logic sda_i,
	// behaviour select
	input wire logic ack_en_i,
	input wire logic arb_i,
	// pull-downs and stop count
	output logic     scl_oe_o,
	output logic     sda_oe_o,
	output var int   stops_o
);
	logic       ps = 1'b1;
	logic       pd = 1'b1;
	logic       fr = 1'b0;
	logic       ao = 1'b0;
	logic       ts = 1'b0;
	logic       td = 1'b0;
	logic [3:0] cnt = 4'h0;
	initial stops_o = 0;
	assign scl_oe_o = ts;
	assign sda_oe_o = td | ao | (arb_i && fr && cnt < 4'h8);
	// frame tracking and acknowledge
	always @(posedge clk_sys_i) begin
		ps <= scl_i;
		pd <= sda_i;
		if (scl_i && ps && pd && !sda_i) begin
			fr <= 1'b1;
			cnt <= 4'h0;
		end else if (scl_i && ps && !pd && sda_i) begin
			fr <= 1'b0;
			ao <= 1'b0;
			stops_o <= stops_o + 1;
		end else if (fr && scl_i && !ps) begin
			cnt <= cnt + 4'h1;
		end else if (fr && !scl_i && ps) begin
			ao <= cnt == 4'h8 && ack_en_i;
			if (cnt == 4'h9) begin
				cnt <= 4'h0;
			end
		end
	end
	// start, three bits, then stop inside the byte
	task err_frame;
		begin
			td <= 1'b1;
			repeat (20) @(posedge clk_sys_i);
			repeat (3) begin
				ts <= 1'b1;
				repeat (20) @(posedge clk_sys_i);
				ts <= 1'b0;
				repeat (20) @(posedge clk_sys_i);
			end
			td <= 1'b0;
			repeat (20) @(posedge clk_sys_i);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/twc_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module twc_ctrl_checker (
	// clock, reset
	input wire logic        clk_sys_i,
	input wire logic        reset_n_i,
	// register bus
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// interrupt and lines
	input wire logic        global_irq_enable_i,
	input wire logic        irq_o,
	input wire logic        scl_oe_o,
	input wire logic        sda_oe_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	logic [2:0] wsh;
	wire        rok  = avs_read_i && !avs_waitrequest_o;
	wire        wok  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	wire        rsts = rok && avs_address_i == 8'hC0;
	wire [7:0]  rb   = avs_readdata_o[7:0];
	// recent control writes
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wsh <= 3'h0;
		end else begin
			wsh <= {wsh[1:0], wok && avs_address_i == 8'hBC};
		end
	end
	property p_irq_gie; !global_irq_enable_i |=> !irq_o; endproperty
	a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
	property p_irq_clr; $fell(irq_o) |-> wsh != 3'h0 || !$past(global_irq_enable_i); endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("flag dropped without write");
	property p_off;
		wok && avs_address_i == 8'hBC && !avs_writedata_i[2] |=> ##[0:2] (!scl_oe_o && !sda_oe_o);
	endproperty
	a_off: assert property (p_off) else $error("lines held after disable");
	property p_berr; rsts && rb == 8'h00 |-> !scl_oe_o && !sda_oe_o; endproperty
	a_berr: assert property (p_berr) else $error("lines held in bus error");
	property p_hold; rsts && rb inside {8'h08, 8'h10, 8'h18, 8'h48} |-> scl_oe_o; endproperty
	a_hold: assert property (p_hold) else $error("scl not stretched");
	property p_sts; rsts && irq_o |-> rb != 8'hF8; endproperty
	a_sts: assert property (p_sts) else $error("idle status while flag set");
	property p_flag; rok && avs_address_i == 8'hBC && irq_o |-> rb[7]; endproperty
	a_flag: assert property (p_flag) else $error("flag reads low while irq");
	property p_brd; rok && avs_address_i == 8'hB8 |-> avs_readdata_o[31:8] == 24'h000000; endproperty
	a_brd: assert property (p_brd) else $error("divider wider than 8 bits");
	c_start: cover property (rsts && rb == 8'h08);
	c_berr: cover property (rsts && rb == 8'h00);
	c_irq: cover property ($fell(irq_o));
endmodule
bind twc_ctrl twc_ctrl_checker chk_u (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
	.global_irq_enable_i, .irq_o, .scl_oe_o, .sda_oe_o);
`default_nettype wire

// ---- tb/twc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module twc_ctrl_tb_top;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        gie = 1'b0;
	logic        mack = 1'b1;
	logic        arb = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [7:0]  v;
	logic [7:0]  r;
	logic [31:0] wd = 32'h00000000;
	wire  [31:0] rdat;
	wire         wreq, irq, scl_oe, sda_oe, m_scl, m_sda;
	wire         scl = ~(scl_oe | m_scl);
	wire         sda = ~(sda_oe | m_sda);
	int          stops;
	int          failures = 0;
	int          comparisons = 0;
	int          seed = 88672;
	int          s0;
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	twc_ctrl dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .global_irq_enable_i(gie),
		.irq_o(irq), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
		.sda_oe_o(sda_oe));
	twc_bus_model mdl_u (.clk_sys_i(clk_sys_i), .scl_i(scl), .sda_i(sda), .ack_en_i(mack),
		.arb_i(arb), .scl_oe_o(m_scl), .sda_oe_o(m_sda), .stops_o(stops));
	// one bus access, read data left in v
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		begin
			adr <= a;
			wd <= {24'h000000, d};
			if (w) wr <= 1'b1;
			else rd <= 1'b1;
			do begin
				@(posedge clk_sys_i);
			end while (wreq !== 1'b0);
			v = rdat[7:0];
			wr <= 1'b0;
			rd <= 1'b0;
			@(posedge clk_sys_i);
		end
	endtask
	// poll the flag, then read status
	task wj;
		begin
			do begin
				acc(0, 8'hBC, 8'h00);
			end while (v[7] !== 1'b1);
			acc(0, 8'hC0, 8'h00);
		end
	endtask
	// expected control read: flag, written rw bits, collision flag
	function automatic logic [7:0] exp_ctl(input logic f, input logic [7:0] w, input logic c);
		exp_ctl = {f, w[6:4], c, w[2], 1'b0, w[0]};
	endfunction
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask
	initial begin
		#600000;
		failures++;
		end_of_test;
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		acc(0, 8'hB8, 8'h00); `CK("brd", 8'h00, v)
		acc(0, 8'hBC, 8'h00); `CK("ctl", 8'h00, v)
		acc(0, 8'hC0, 8'h00); `CK("sts", 8'hF8, v)
		acc(0, 8'h10, 8'h00); `CK("unmapped", 8'h00, v)
		repeat (4) begin
			r = $random(seed);
			acc(1, 8'hB8, r);
			acc(0, 8'hB8, 8'h00); `CK("brd", r, v)
			acc(1, 8'hC8, r);
			acc(0, 8'hC8, 8'h00); `CK("own", r, v)
		end
		acc(1, 8'hB8, 8'h00);
		acc(1, 8'hBC, 8'h0B);
		acc(0, 8'hBC, 8'h00); `CK("ctl", exp_ctl(1'b0, 8'h0B, 1'b0), v)
		acc(1, 8'hC4, 8'h55);
		acc(0, 8'hBC, 8'h00); `CK("ctl", exp_ctl(1'b0, 8'h0B, 1'b1), v)
		// master start, stretch, interrupt
		gie <= 1'b1;
		acc(1, 8'hBC, 8'hA5);
		wj; `CK("sts", 8'h08, v)
		`CK("scl_oe", 1'b1, scl_oe)
		repeat (2) @(posedge clk_sys_i);
		`CK("irq", 1'b1, irq)
		gie <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		`CK("irq", 1'b0, irq)
		gie <= 1'b1;
		repeat (50) @(posedge clk_sys_i);
		acc(0, 8'hBC, 8'h00); `CK("ctl", exp_ctl(1'b1, 8'hA5, 1'b1), v)
		acc(1, 8'hC4, 8'hA0);
		acc(0, 8'hBC, 8'h00); `CK("ctl", exp_ctl(1'b1, 8'hA5, 1'b0), v)
		acc(1, 8'hBC, 8'h85);
		wj; `CK("sts", 8'h18, v)
		// repeated start into read direction
		acc(1, 8'hBC, 8'hA5);
		wj; `CK("sts", 8'h10, v)
		`CK("scl_oe", 1'b1, scl_oe)
		acc(1, 8'hC4, 8'hA1);
		mack <= 1'b0;
		acc(1, 8'hBC, 8'h85);
		wj; `CK("sts", 8'h48, v)
		s0 = stops;
		acc(1, 8'hBC, 8'h95);
		do begin
			acc(0, 8'hBC, 8'h00);
		end while (v[4] !== 1'b0);
		repeat (5) @(posedge clk_sys_i);
		`CK("ctl", 8'h05, v)
		`CK("stops", s0 + 1, stops)
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		acc(0, 8'hC0, 8'h00); `CK("sts", 8'hF8, v)
		// bus error and recovery
		mack <= 1'b1;
		acc(1, 8'hBC, 8'h44);
		mdl_u.err_frame;
		wj; `CK("sts", 8'h00, v)
		acc(0, 8'hBC, 8'h00); `CK("ctl", exp_ctl(1'b1, 8'h44, 1'b0), v)
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		s0 = stops;
		acc(1, 8'hBC, 8'hD4);
		repeat (5) @(posedge clk_sys_i);
		acc(0, 8'hBC, 8'h00); `CK("ctl", 8'h44, v)
		acc(0, 8'hC0, 8'h00); `CK("sts", 8'hF8, v)
		`CK("stops", s0, stops)
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		// switch off while holding the bus
		acc(1, 8'hBC, 8'hA4);
		wj; `CK("scl_oe", 1'b1, scl_oe)
		acc(1, 8'hBC, 8'h00);
		repeat (2) @(posedge clk_sys_i);
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		// second master sends the same address, then wins in the data
		acc(1, 8'hBC, 8'hA4);
		wj;
		acc(1, 8'hC4, 8'h00);
		arb <= 1'b1;
		acc(1, 8'hBC, 8'h84);
		wj; `CK("sts", 8'h18, v)
		acc(1, 8'hC4, 8'hFF);
		acc(1, 8'hBC, 8'h84);
		wj; `CK("sts", 8'h38, v)
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		acc(1, 8'hBC, 8'h84);
		acc(0, 8'hC0, 8'h00); `CK("sts", 8'hF8, v)
		`CK("lines", 2'b00, {scl_oe, sda_oe})
		end_of_test;
	end
endmodule
`default_nettype wire

// ---- verilog/twc_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "twc_map.vh"
// How it works
// - status reads F8 whenever the job-done flag is clear.
// - start or stop inside a byte or ack gives status 00.
// - a bus error sets the job-done flag.
// - stop request plus flag clear after bus error: unaddressed slave, stop request cleared.
// - bus error recovery releases both lines and sends no stop.
// - repeated start changes direction and keeps bus ownership.
// - sending one in an address or data bit while bus reads zero loses arbitration.
// - identical traffic from several masters never loses arbitration.
// - lost in data or direction: unaddressed slave, or start again when free.
// - lost in address: continue as slave, compare address, enter rx or tx.
// - eight-bit divider sets scl rate in master modes; resets to zero.
// - job-done flag is set when a job ends and software must answer.
// - interrupt only when global enable, block enable and job-done flag are set.
// - scl is held low while the job-done flag is set, except with status 00, 38 or A0.
// - job-done flag clears only by writing one to it.
// - clearing the job-done flag starts the next operation.
// - data write while job-done flag is low sets write collision.
// - data write while job-done flag is high clears write collision.
// - stop request without start request in master mode sends stop, then self-clears.
// - clearing interface enable stops all activity at once.
module twc_ctrl (
	// system
	input  wire        clk_sys_i,
	input  wire        reset_n_i,
	// avalon-mm slave
	input  wire [7:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	// interrupt
	input  wire        global_irq_enable_i,
	output reg         irq_o,
	// two-wire bus, open drain
	input  wire        scl_i,
	output reg         scl_o,
	output reg         scl_oe_o,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe_o
);

localparam S_IDLE = 3'h0;
localparam S_WAIT = 3'h1;
localparam S_MSTART = 3'h2;
localparam S_MBIT = 3'h3;
localparam S_MSTOP = 3'h4;
localparam S_SBIT = 3'h5;
localparam PH0 = 2'h0;
localparam PH1 = 2'h1;
localparam PH2 = 2'h2;

reg  [7:0] bit_rate_divider;
reg  [7:0] data_reg;
reg  [7:0] own_address_reg;
reg  [7:0] status_code;
reg        job_done_flag;
reg        ack_enable;
reg        start_request;
reg        stop_request;
reg        write_collision_flag;
reg        interface_enable;
reg        irq_enable;
reg  [2:0] st;
reg  [1:0] ph;
reg  [3:0] bit_cnt;
reg  [7:0] shreg;
reg  [8:0] tcnt;
reg        is_master;
reg        is_tx;
reg        is_addr;
reg        is_gc;
reg        addressed;
reg        arb_lost_adr;
reg        ack_rx;
reg        ack_sent;
reg        last_byte;
reg        term;
reg        bus_busy;
reg        scl_prev;
reg        sda_prev;
reg  [7:0] next_code;
reg        next_term;
reg  [7:0] rd_mux;

wire [7:0] wd = avs_writedata_i[7:0];
wire       wr_acc = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
wire       wr_ctl = wr_acc & (avs_address_i == `TWC_CTL_ADDR);
wire       wr_dat = wr_acc & (avs_address_i == `TWC_DAT_ADDR);
wire       go = wr_ctl & wd[`TWC_B_DONE] & job_done_flag;
wire       scl_rise = scl_i & ~scl_prev;
wire       scl_fall = ~scl_i & scl_prev;
wire       cond_start = scl_i & scl_prev & sda_prev & ~sda_i;
wire       cond_stop = scl_i & scl_prev & ~sda_prev & sda_i;
wire       in_byte = (st == S_MBIT) | ((st == S_SBIT) & (bit_cnt != 4'h0));
wire       berr_ev = (cond_start | cond_stop) & in_byte;
wire       m_run = (st == S_MSTART) | (st == S_MBIT) | (st == S_MSTOP);
wire       stretch = (ph == PH1) & ~scl_i;
wire       tick = m_run & ~stretch & (tcnt == 9'h000);
wire       we_send = is_tx | is_addr;
wire       arb_hit = (bit_cnt < `TWC_ACK_BIT) & we_send & ~sda_oe_o & ~sda_i;
wire       gc_hit = own_address_reg[0] & (shreg[7:1] == 7'h00) & ~shreg[0];
wire       adr_match = ack_enable & ((shreg[7:1] == own_address_reg[7:1]) | gc_hit);
wire [3:0] bit_nx = bit_cnt + 4'h1;
wire [7:0] gc_or = is_gc ? `TWC_ST_GC : `TWC_RST8;

// status and end-of-service for the byte just finished
always @* begin
	next_term = 1'b0;
	if (is_master) begin
		if (is_addr && is_tx)
			next_code = ack_rx ? `TWC_ST_MTA_ACK : `TWC_ST_MTA_NACK;
		else if (is_addr)
			next_code = ack_rx ? `TWC_ST_MRA_ACK : `TWC_ST_MRA_NACK;
		else if (is_tx)
			next_code = ack_rx ? `TWC_ST_MTD_ACK : `TWC_ST_MTD_NACK;
		else
			next_code = ack_sent ? `TWC_ST_MRD_ACK : `TWC_ST_MRD_NACK;
	end else if (is_addr) begin
		if (is_tx)
			next_code = arb_lost_adr ? `TWC_ST_STA_ARB : `TWC_ST_STA;
		else
			next_code = (arb_lost_adr ? `TWC_ST_SRA_ARB : `TWC_ST_SRA) | gc_or;
	end else if (is_tx) begin
		next_term = ~ack_rx | last_byte;
		if (!ack_rx)
			next_code = `TWC_ST_STD_NACK;
		else
			next_code = last_byte ? `TWC_ST_STD_LAST : `TWC_ST_STD_ACK;
	end else begin
		next_term = ~ack_sent;
		next_code = (ack_sent ? `TWC_ST_SRD_ACK : `TWC_ST_SRD_NACK) | gc_or;
	end
end

// register read mux
always @* begin
	case (avs_address_i)
	`TWC_BRD_ADDR: rd_mux = bit_rate_divider;
	`TWC_CTL_ADDR: rd_mux = {job_done_flag, ack_enable, start_request, stop_request,
		write_collision_flag, interface_enable, 1'b0, irq_enable};
	`TWC_STS_ADDR: rd_mux = job_done_flag ? status_code : `TWC_ST_IDLE;
	`TWC_DAT_ADDR: rd_mux = data_reg;
	`TWC_OWN_ADDR: rd_mux = own_address_reg;
	default: rd_mux = `TWC_RST8;
	endcase
end

// avalon answer: one wait cycle, then a single accept cycle
always @(posedge clk_sys_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		avs_waitrequest_o <= 1'b1;
		avs_readdata_o <= {`TWC_RST24, `TWC_RST8};
		irq_o <= 1'b0;
	end else begin
		irq_o <= job_done_flag & irq_enable & global_irq_enable_i;
		if ((avs_read_i | avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= {`TWC_RST24, rd_mux};
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end
end

// one-third-period timer for master scl
always @(posedge clk_sys_i or negedge reset_n_i) begin
	if (!reset_n_i)
		tcnt <= `TWC_HALF_BASE;
	else if (!m_run || stretch || tick)
		tcnt <= `TWC_HALF_BASE + {1'b0, bit_rate_divider};
	else
		tcnt <= tcnt - 9'h001;
end

// registers and bus engine
always @(posedge clk_sys_i or negedge reset_n_i) begin
	if (!reset_n_i) begin
		bit_rate_divider <= `TWC_RST8;
		data_reg <= `TWC_RST8;
		own_address_reg <= `TWC_RST8;
		status_code <= `TWC_ST_IDLE;
		job_done_flag <= 1'b0;
		ack_enable <= 1'b0;
		start_request <= 1'b0;
		stop_request <= 1'b0;
		write_collision_flag <= 1'b0;
		interface_enable <= 1'b0;
		irq_enable <= 1'b0;
		st <= S_IDLE;
		ph <= PH0;
		bit_cnt <= 4'h0;
		shreg <= `TWC_RST8;
		is_master <= 1'b0;
		is_tx <= 1'b0;
		is_addr <= 1'b0;
		is_gc <= 1'b0;
		addressed <= 1'b0;
		arb_lost_adr <= 1'b0;
		ack_rx <= 1'b0;
		ack_sent <= 1'b0;
		last_byte <= 1'b0;
		term <= 1'b0;
		bus_busy <= 1'b0;
		scl_prev <= 1'b1;
		sda_prev <= 1'b1;
		scl_o <= 1'b0;
		sda_o <= 1'b0;
		scl_oe_o <= 1'b0;
		sda_oe_o <= 1'b0;
	end else begin
		scl_prev <= scl_i;
		sda_prev <= sda_i;
		if (cond_start)
			bus_busy <= 1'b1;
		else if (cond_stop)
			bus_busy <= 1'b0;
		if (wr_acc && avs_address_i == `TWC_BRD_ADDR)
			bit_rate_divider <= wd;
		if (wr_acc && avs_address_i == `TWC_OWN_ADDR)
			own_address_reg <= wd;
		if (wr_ctl) begin
			ack_enable <= wd[`TWC_B_ACK];
			start_request <= wd[`TWC_B_STA];
			stop_request <= wd[`TWC_B_STO];
			interface_enable <= wd[`TWC_B_EN];
			irq_enable <= wd[`TWC_B_IE];
			if (wd[`TWC_B_DONE])
				job_done_flag <= 1'b0;
		end
		if (wr_dat && job_done_flag) begin
			data_reg <= wd;
			write_collision_flag <= 1'b0;
		end else if (wr_dat) begin
			write_collision_flag <= 1'b1;
		end
		if (!interface_enable) begin
			st <= S_IDLE;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			is_master <= 1'b0;
			addressed <= 1'b0;
			bus_busy <= 1'b0;
		end else if (berr_ev) begin
			status_code <= `TWC_ST_BERR;
			job_done_flag <= 1'b1;
			term <= 1'b1;
			st <= S_WAIT;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			is_master <= 1'b0;
			addressed <= 1'b0;
		end else begin
			case (st)
			S_IDLE: begin
				scl_oe_o <= 1'b0;
				sda_oe_o <= 1'b0;
				if (cond_start) begin
					st <= S_SBIT;
					bit_cnt <= 4'h0;
					is_addr <= 1'b1;
					is_gc <= 1'b0;
					arb_lost_adr <= 1'b0;
				end else if (start_request && !bus_busy && !job_done_flag) begin
					st <= S_MSTART;
					ph <= PH1;
				end
			end
			S_WAIT: begin
				if (go) begin
					bit_cnt <= 4'h0;
					if (term) begin
						st <= S_IDLE;
						scl_oe_o <= 1'b0;
						sda_oe_o <= 1'b0;
						addressed <= 1'b0;
						if (status_code == `TWC_ST_BERR)
							stop_request <= 1'b0;
					end else if (is_master && wd[`TWC_B_STA]) begin
						st <= S_MSTART;
						ph <= PH0;
						sda_oe_o <= 1'b0;
					end else if (is_master && wd[`TWC_B_STO]) begin
						st <= S_MSTOP;
						ph <= PH0;
						sda_oe_o <= 1'b1;
					end else if (is_master) begin
						st <= S_MBIT;
						ph <= PH0;
						shreg <= data_reg;
						sda_oe_o <= we_send & ~data_reg[7];
						if (is_addr)
							is_tx <= ~data_reg[0];
					end else begin
						st <= S_SBIT;
						scl_oe_o <= 1'b0;
						sda_oe_o <= is_tx & ~data_reg[7];
						shreg <= data_reg;
						last_byte <= ~ack_enable;
					end
				end
			end
			S_MSTART: begin
				if (tick) begin
					case (ph)
					PH0: begin
						scl_oe_o <= 1'b0;
						ph <= PH1;
					end
					PH1: begin
						sda_oe_o <= 1'b1;
						ph <= PH2;
					end
					default: begin
						scl_oe_o <= 1'b1;
						status_code <= is_master ? `TWC_ST_RSTART : `TWC_ST_START;
						is_master <= 1'b1;
						is_addr <= 1'b1;
						term <= 1'b0;
						job_done_flag <= 1'b1;
						st <= S_WAIT;
					end
					endcase
				end
			end
			S_MBIT: begin
				if (tick) begin
					case (ph)
					PH0: begin
						scl_oe_o <= 1'b0;
						ph <= PH1;
					end
					PH1: begin
						if (bit_cnt < `TWC_ACK_BIT)
							shreg <= {shreg[6:0], sda_i};
						else
							ack_rx <= ~sda_i;
						if (arb_hit && is_addr) begin
							is_master <= 1'b0;
							arb_lost_adr <= 1'b1;
							bit_cnt <= bit_nx;
							st <= S_SBIT;
						end else if (arb_hit) begin
							is_master <= 1'b0;
							status_code <= `TWC_ST_ARB;
							job_done_flag <= 1'b1;
							term <= 1'b1;
							st <= S_WAIT;
						end else begin
							scl_oe_o <= 1'b1;
							ph <= PH2;
						end
					end
					default: begin
						if (bit_cnt == `TWC_ACK_BIT) begin
							status_code <= next_code;
							job_done_flag <= 1'b1;
							term <= 1'b0;
							st <= S_WAIT;
							sda_oe_o <= 1'b0;
							is_addr <= 1'b0;
							if (!we_send)
								data_reg <= shreg;
						end else if (bit_nx == `TWC_ACK_BIT) begin
							bit_cnt <= bit_nx;
							ph <= PH0;
							ack_sent <= ~we_send & ack_enable;
							sda_oe_o <= ~we_send & ack_enable;
						end else begin
							bit_cnt <= bit_nx;
							ph <= PH0;
							sda_oe_o <= we_send & ~shreg[7];
						end
					end
					endcase
				end
			end
			S_MSTOP: begin
				if (tick) begin
					case (ph)
					PH0: begin
						scl_oe_o <= 1'b0;
						ph <= PH1;
					end
					PH1: begin
						sda_oe_o <= 1'b0;
						ph <= PH2;
					end
					default: begin
						stop_request <= 1'b0;
						is_master <= 1'b0;
						st <= S_IDLE;
					end
					endcase
				end
			end
			S_SBIT: begin
				if ((cond_start || cond_stop) && addressed && !is_tx) begin
					status_code <= `TWC_ST_SR_STOP;
					job_done_flag <= 1'b1;
					term <= 1'b1;
					addressed <= 1'b0;
					st <= S_WAIT;
				end else if (cond_stop) begin
					st <= S_IDLE;
				end else if (cond_start) begin
					is_addr <= 1'b1;
					addressed <= 1'b0;
					arb_lost_adr <= 1'b0;
				end else if (scl_rise) begin
					if (bit_cnt < `TWC_ACK_BIT)
						shreg <= {shreg[6:0], sda_i};
					else
						ack_rx <= ~sda_i;
					bit_cnt <= bit_nx;
				end else if (scl_fall && bit_cnt == `TWC_ACK_BIT) begin
					if (is_addr && adr_match) begin
						sda_oe_o <= 1'b1;
						addressed <= 1'b1;
						is_tx <= shreg[0];
						is_gc <= gc_hit;
					end else if (is_addr && arb_lost_adr) begin
						status_code <= `TWC_ST_ARB;
						job_done_flag <= 1'b1;
						term <= 1'b1;
						st <= S_WAIT;
					end else if (is_addr) begin
						st <= S_IDLE;
					end else if (!is_tx) begin
						sda_oe_o <= ack_enable;
						ack_sent <= ack_enable;
						data_reg <= shreg;
					end else begin
						sda_oe_o <= 1'b0;
					end
				end else if (scl_fall && bit_cnt == `TWC_END_BIT) begin
					status_code <= next_code;
					term <= next_term;
					job_done_flag <= 1'b1;
					scl_oe_o <= 1'b1;
					sda_oe_o <= 1'b0;
					is_addr <= 1'b0;
					st <= S_WAIT;
				end else if (scl_fall && is_tx && addressed && !is_addr) begin
					sda_oe_o <= ~shreg[7];
				end
			end
			default: st <= S_IDLE;
			endcase
		end
	end
end

endmodule
`default_nettype wire

// ---- verilog/twc_map.vh ----
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
// register byte offsets
`define TWC_BRD_ADDR 8'hB8
`define TWC_CTL_ADDR 8'hBC
`define TWC_STS_ADDR 8'hC0
`define TWC_DAT_ADDR 8'hC4
`define TWC_OWN_ADDR 8'hC8
// control register bit positions
`define TWC_B_DONE 7
`define TWC_B_ACK 6
`define TWC_B_STA 5
`define TWC_B_STO 4
`define TWC_B_EN 2
`define TWC_B_IE 0
// reset values
`define TWC_RST8 8'h00
`define TWC_RST24 24'h000000
// a third of the scl period in cycles is this base plus the divider plus one
`define TWC_HALF_BASE 9'h008
// frame bit counts
`define TWC_ACK_BIT 4'h8
`define TWC_END_BIT 4'h9
// status codes
`define TWC_ST_IDLE 8'hF8
`define TWC_ST_BERR 8'h00
`define TWC_ST_START 8'h08
`define TWC_ST_RSTART 8'h10
`define TWC_ST_MTA_ACK 8'h18
`define TWC_ST_MTA_NACK 8'h20
`define TWC_ST_MTD_ACK 8'h28
`define TWC_ST_MTD_NACK 8'h30
`define TWC_ST_ARB 8'h38
`define TWC_ST_MRA_ACK 8'h40
`define TWC_ST_MRA_NACK 8'h48
`define TWC_ST_MRD_ACK 8'h50
`define TWC_ST_MRD_NACK 8'h58
`define TWC_ST_SRA 8'h60
`define TWC_ST_SRA_ARB 8'h68
`define TWC_ST_SRD_ACK 8'h80
`define TWC_ST_SRD_NACK 8'h88
`define TWC_ST_GC 8'h10
`define TWC_ST_SR_STOP 8'hA0
`define TWC_ST_STA 8'hA8
`define TWC_ST_STA_ARB 8'hB0
`define TWC_ST_STD_ACK 8'hB8
`define TWC_ST_STD_NACK 8'hC0
`define TWC_ST_STD_LAST 8'hC8
`endif
